// file: cscc_pkg.sv
package cscc_pkg;
    // Timing of the power-on reset interval and the error pulse on the status line
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned STATUS_PULSE_MIN_US = 10;
    localparam int unsigned STATUS_PULSE_MAX_US = 500;
    // Least time rounds up to whole cycles
    localparam int unsigned STATUS_PULSE_CYC =
        (STATUS_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STATUS_PULSE_MAX_CYC = (STATUS_PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned POR_CYC_DEFAULT  = 5000;
    localparam int unsigned INIT_CYC_DEFAULT = 16;
    localparam int unsigned CNT_W            = 20;
    localparam logic [CNT_W-1:0] CNT_RESET   = 20'h00000;

    typedef enum logic [2:0] {
        CSCC_POR,
        CSCC_IDLE,
        CSCC_CONFIG,
        CSCC_WAIT_DONE,
        CSCC_INIT,
        CSCC_USER,
        CSCC_ERROR
    } cscc_state_t;
endpackage

// file: cscc_ctrl.sv
`timescale 1ns/10ps
module cscc_ctrl
    import cscc_pkg::*;
#(
    parameter int unsigned POR_CYC  = POR_CYC_DEFAULT,
    parameter int unsigned INIT_CYC = INIT_CYC_DEFAULT
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic chip_enable_n,
    input  wire logic config_request_n,
    input  wire logic active_serial_mode,
    input  wire logic auto_restart_en,
    input  wire logic data_word_valid,
    input  wire logic data_last,
    input  wire logic data_error,
    input  wire logic config_complete_in,
    output logic      config_complete_out,
    output logic      config_complete_oe,
    input  wire logic status_in,
    output logic      status_out,
    output logic      status_oe,
    output logic      chain_enable_n,
    output logic      serial_cmd_out,
    output logic      serial_select_n,
    output logic      user_mode
);
    // All state in one word: the comb block builds a copy, one flop stage holds it
    typedef struct packed {
        cscc_state_t      state;
        logic [CNT_W-1:0] cnt;
        logic             status_low;
        logic             done_low;
        logic             chain_n;
        logic             sel_n;
        logic             cmd;
        logic             user;
    } cscc_regs_t;

    cscc_regs_t s_reg;
    cscc_regs_t s_next;

    // Counters run from zero, so a span of lim cycles ends when the count
    // reaches lim - 1
    function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input int unsigned lim);
        return c >= CNT_W'(lim - 1);
    endfunction

    // Entering the error state pulls status low on the same edge, so the
    // pulse is counted in full from its first cycle
    function automatic cscc_regs_t enter_error(input cscc_regs_t r);
        cscc_regs_t e;
        e            = r;
        e.state      = CSCC_ERROR;
        e.cnt        = CNT_RESET;
        e.status_low = 1'b1;
        return e;
    endfunction

    // Back to idle: status released, complete held low, serial memory deselected
    function automatic cscc_regs_t release_to_idle(input cscc_regs_t r);
        cscc_regs_t i;
        i            = r;
        i.state      = CSCC_IDLE;
        i.status_low = 1'b0;
        i.done_low   = 1'b1;
        i.sel_n      = 1'b1;
        i.cmd        = 1'b0;
        return i;
    endfunction

    always_comb begin
        s_next     = s_reg;
        s_next.cnt = s_reg.cnt + CNT_W'(1);
        unique case (s_reg.state)
            // Power-on: both open-drain lines held low; requests are not looked at,
            // so an attempt this early simply waits until the interval ends
            CSCC_POR: begin
                s_next.status_low = 1'b1;
                s_next.done_low   = 1'b1;
                if (cnt_hit(s_reg.cnt, POR_CYC)) begin
                    s_next.status_low = 1'b0;
                    s_next.state      = CSCC_IDLE;
                    s_next.cnt        = CNT_RESET;
                end
            end

            // Waiting for chip enable; a start needs the status net seen high,
            // which is what gives the automatic retry after power-on
            CSCC_IDLE: begin
                s_next.done_low = 1'b1;
                // Wired level is used: a host holding status low delays the start
                if (!chip_enable_n && config_request_n && status_in) begin
                    s_next.state = CSCC_CONFIG;
                end
            end

            // Loading: data words arrive on the strobe. The command line toggles
            // as a read strobe while loading; it stands in for the memory's own
            // command protocol, which this block does not model
            // Limitation: a mode change in mid-load reaches the pins one cycle late
            CSCC_CONFIG: begin
                s_next.sel_n = ~active_serial_mode;
                s_next.cmd   = active_serial_mode & s_reg.cnt[0];
                if (!status_in || data_word_valid && data_error) begin
                    s_next = enter_error(s_next);
                end else if (data_word_valid && data_last) begin
                    s_next.done_low = 1'b0;
                    s_next.sel_n    = 1'b1;
                    s_next.cmd      = 1'b0;
                    s_next.state    = CSCC_WAIT_DONE;
                end
            end

            // Own pull released; another device on the net may still hold it low,
            // so initialization waits for the wired level
            // Nothing bounds this wait: a stuck net keeps the block here
            CSCC_WAIT_DONE: begin
                if (!status_in) begin
                    s_next = enter_error(s_next);
                end else if (config_complete_in) begin
                    s_next.state = CSCC_INIT;
                    s_next.cnt   = CNT_RESET;
                end
            end

            // Fixed-length initialization; chain enable is handed on only at its
            // end so the next device never starts on a half-ready neighbour
            CSCC_INIT: begin
                if (!status_in) begin
                    s_next = enter_error(s_next);
                end else if (cnt_hit(s_reg.cnt, INIT_CYC)) begin
                    s_next.state   = CSCC_USER;
                    s_next.user    = 1'b1;
                    s_next.chain_n = 1'b0;
                end
            end

            // Configured state is kept until a restart request
            CSCC_USER: begin
                // Status and config_complete are not looked at here
                if (!config_request_n) begin
                    s_next.state   = CSCC_IDLE;
                    s_next.user    = 1'b0;
                    s_next.chain_n = 1'b1;
                    s_next.done_low = 1'b1;
                end
            end

            // Error: status is already low from the entering edge; the counter
            // restarted there, so with auto restart and no request the pulse lasts the full minimum width
            CSCC_ERROR: begin
                s_next.done_low = 1'b1;
                s_next.sel_n    = 1'b1;
                s_next.cmd      = 1'b0;
                if (auto_restart_en) begin
                    s_next.status_low = 1'b1;
                    if (cnt_hit(s_reg.cnt, STATUS_PULSE_CYC)) begin
                        s_next.status_low = 1'b0;
                        s_next.state      = CSCC_IDLE;
                    end
                end else begin
                    s_next.status_low = 1'b1;
                    // Without auto restart only a config request clears the error
                    if (!config_request_n) begin
                        s_next.status_low = 1'b0;
                        s_next.state      = CSCC_IDLE;
                    end
                end
            end
        endcase
        // A restart request wins over every state but power-on and user mode,
        // which handles its own request above
        if (s_reg.state != CSCC_POR && s_reg.state != CSCC_USER && !config_request_n) begin
            s_next = release_to_idle(s_next);
        end
    end

    // Reset puts every output at its safe level: status and complete pulled
    // low, serial memory deselected, chain enable high
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg.state      <= CSCC_POR;
            s_reg.cnt        <= CNT_RESET;
            s_reg.status_low <= 1'b1;
            s_reg.done_low   <= 1'b1;
            s_reg.chain_n    <= 1'b1;
            s_reg.sel_n      <= 1'b1;
            s_reg.cmd        <= 1'b0;
            s_reg.user       <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Open-drain: output value is always 0, enable drives the line low
    // The module never drives either line high; a pull-up on the net does that
    assign config_complete_out = 1'b0;
    assign config_complete_oe  = s_reg.done_low;
    assign status_out          = 1'b0;
    assign status_oe           = s_reg.status_low;
    assign chain_enable_n      = s_reg.chain_n;
    assign serial_cmd_out      = s_reg.cmd;
    assign serial_select_n     = s_reg.sel_n;
    assign user_mode           = s_reg.user;
endmodule

// file: cscc_ctrl_properties.sv
`timescale 1ns/10ps
module cscc_ctrl_properties #(
    parameter int unsigned POR_CYC  = 20,
    parameter int unsigned INIT_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic config_request_n,
    input wire logic active_serial_mode,
    input wire logic data_word_valid,
    input wire logic data_last,
    input wire logic data_error,
    input wire logic config_complete_in,
    input wire logic config_complete_oe,
    input wire logic status_in,
    input wire logic status_oe,
    input wire logic chain_enable_n,
    input wire logic serial_cmd_out,
    input wire logic serial_select_n,
    input wire logic user_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Select low stands for the loading phase; the bench runs loads in serial mode
    sequence s_cfg; !serial_select_n; endsequence
    sequence s_last; s_cfg ##0 (data_word_valid && data_last && !data_error); endsequence
    property p_por; $fell(rst) |-> status_oe [*8]; endproperty
    property p_hold; s_cfg |-> config_complete_oe; endproperty
    property p_rel; s_last |=> !config_complete_oe; endproperty
    property p_init; $rose(user_mode) |-> config_complete_in && !config_complete_oe; endproperty
    property p_user; user_mode && config_request_n |=> user_mode; endproperty
    property p_chain; chain_enable_n == !user_mode; endproperty
    property p_as; !active_serial_mode |-> serial_select_n && !serial_cmd_out; endproperty
    property p_err; s_cfg ##0 !status_in |=> status_oe; endproperty
    a_por: assert property (p_por) else $error("status released too soon");
    a_hold: assert property (p_hold) else $error("complete released in load");
    a_rel: assert property (p_rel) else $error("complete held after last word");
    a_init: assert property (p_init) else $error("user mode without complete");
    a_user: assert property (p_user) else $error("user mode left");
    a_chain: assert property (p_chain) else $error("chain enable wrong");
    a_as: assert property (p_as) else $error("serial pins active off mode");
    a_err: assert property (p_err) else $error("status pull not seen");
endmodule
bind cscc_ctrl cscc_ctrl_properties #(.POR_CYC(POR_CYC), .INIT_CYC(INIT_CYC)) chk (.*);

// file: cscc_far.sv
`timescale 1ns/10ps
module cscc_far (
    input  wire logic ce_on,
    input  wire logic cc_pull,
    input  wire logic st_pull,
    input  wire logic config_complete_oe,
    input  wire logic status_oe,
    output logic      chip_enable_n,
    output logic      config_complete_in,
    output logic      status_in
);
    // First device of the chain, enable held low for the whole run
    assign chip_enable_n = !ce_on;
    // Pulled-up nets: any party pulling low wins
    assign config_complete_in = !(config_complete_oe || cc_pull);
    assign status_in = !(status_oe || st_pull);
endmodule

// file: config_status_chain_control_bench.sv
`timescale 1ns/10ps
module config_status_chain_control_bench;
    import cscc_pkg::*;
    logic clk_sys = 0, rst = 1, ce_on = 1, config_request_n = 1, active_serial_mode = 0;
    logic auto_restart_en = 1, data_word_valid = 0, data_last = 0, data_error = 0;
    logic cc_pull = 0, st_pull = 0, chip_enable_n, config_complete_in, config_complete_oe;
    logic status_in, status_oe, chain_enable_n, serial_cmd_out, serial_select_n, user_mode;
    int failures = 0, compares = 0, n;
    cscc_ctrl #(.POR_CYC(20), .INIT_CYC(4)) uut (.*, .config_complete_out(), .status_out());
    cscc_far far (.*);
    initial forever #2 clk_sys = ~clk_sys;
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    // An idle edge follows each word so back-to-back calls never raise valid
    // in the step that lowered it
    task automatic word(input logic last);
        data_word_valid = 1;
        data_last = last;
        cyc(1);
        data_word_valid = 0;
        data_last = 0;
        cyc(1);
    endtask
    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_por;
        cyc(10);
        chk(status_in === 1'b0, "status released early");
        chk(serial_select_n === 1'b1, "load before power-on");
        active_serial_mode = 1;
        n = 0;
        while (status_in !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        chk(n >= 5 && n <= 14, "power-on interval");
        cyc(2);
        chk(serial_select_n === 1'b0, "no automatic load");
    endtask
    task automatic t_cfg;
        logic c0;
        c0 = serial_cmd_out;
        cyc(1);
        chk(serial_cmd_out !== c0, "serial command idle");
        word(0);
        word(0);
        chk(config_complete_in === 1'b0, "complete early");
        word(1);
        cyc(1);
        chk(config_complete_in === 1'b1 && serial_select_n === 1'b1, "complete held");
        cyc(2);
        chk(chain_enable_n === 1'b1, "chain enable early");
        cyc(4);
        chk(user_mode === 1'b1 && chain_enable_n === 1'b0, "no user mode");
    endtask
    task automatic t_user;
        cc_pull = 1;
        st_pull = 1;
        cyc(5);
        chk(user_mode === 1'b1, "user mode lost");
        cc_pull = 0;
        st_pull = 0;
        config_request_n = 0;
        cyc(2);
        chk(user_mode === 1'b0 && config_complete_in === 1'b0, "request ignored");
        config_request_n = 1;
        cyc(3);
        chk(serial_select_n === 1'b0, "no reload");
    endtask
    task automatic t_err;
        st_pull = 1;
        cyc(1);
        st_pull = 0;
        cyc(1);
        n = 0;
        while (status_in !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        chk(n + 2 >= STATUS_PULSE_CYC && n <= STATUS_PULSE_MAX_CYC, "error pulse");
        cyc(3);
        chk(serial_select_n === 1'b0, "no retry");
    endtask
    task automatic t_derr;
        auto_restart_en = 0;
        data_error = 1;
        word(0);
        data_error = 0;
        cyc(10);
        chk(status_in === 1'b0 && serial_select_n === 1'b1, "data error not held");
        config_request_n = 0;
        cyc(1);
        config_request_n = 1;
        cyc(3);
        chk(status_in === 1'b1 && serial_select_n === 1'b0, "no restart after request");
    endtask
    initial begin
        cyc(20);
        rst = 0;
        t_por;
        t_cfg;
        t_user;
        t_err;
        t_derr;
        complete_run;
    end
    // About 2600 cycles expected; cut off at ten thousand
    initial begin
        #40000;
        failures++;
        complete_run;
    end
endmodule
